// ### design/hdp_host_port.sv
// host data port: byte-wide host side, word-wide core side, handshake and interrupts
// Summary of operation
// - host high-byte write clears write-ready flag
// - same write drives write-ready pin high
// - same write raises host input interrupt
// - core load sets write-ready flag again
// - core load drives write-ready pin low
// - store stalls while wait enabled, read-ready set
// - load stalls while wait enabled, write-ready set
// - stalled store waits for host read, no timeout
// - interrupts deferred while core is stalled
// - output interrupt on read strobe rising, high byte
// - status write sets wait, masks, clears error flags
// - input vector 0x230, output vector 0x234
// - core status bits mask both interrupts
// - global block acts two instruction cycles later
// - read-ready flag readable at status bit one
// - software primes output with a dummy store
// - software disables output interrupt before last word
// - pin mask forces pin high, else follows flag
// - host write while not ready sets sticky error
// - status reads 0x0301 after reset
`timescale 1ns/1ps
`include "hdp_defines.svh"
module hdp_host_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // core peripheral bus, request held until ack
  input wire logic [15:0] coreAddr,
  input wire logic coreLoad,
  input wire logic coreStore,
  input wire logic [15:0] coreWrData,
  output logic [15:0] coreRdData_ff,
  output logic coreAck_ff,
  output logic coreWait_ff,
  // core interrupt context
  input wire logic [15:0] coreStatusWord,
  input wire logic [15:0] irqEnableWord,
  input wire logic instrStep,
  input wire logic flushIrq,
  output logic irqReq_ff,
  output logic [15:0] irqVector_ff,
  // host pins, strobes active low
  input wire logic hostCsN,
  input wire logic hostRdN,
  input wire logic hostWrN,
  input wire hdp_pkg::hdp_hsel_t hostAddr,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut_ff,
  output logic hostDataOe_ff,
  output logic writeReadyPinN_ff,
  output logic readReadyPinN_ff
);
  import hdp_pkg::*;

  // synchronised host pins
  logic [12:0] hostSync; // {csN, rdN, wrN, addr, data}
  logic csN;
  logic rdN;
  logic wrN;
  hdp_hsel_t hSel;
  logic [7:0] hData;
  logic rdNPrev_ff; // previous read strobe level
  logic wrNPrev_ff; // previous write strobe level
  logic hostRdRise; // end of a host read cycle
  logic hostWrRise; // end of a host write cycle

  // port registers
  logic [15:0] status_ff; // host_port_status
  logic [15:0] inWord_ff; // host_data_in_alias
  logic [15:0] outWord_ff; // host_data_out_alias
  logic [7:0] inLow_ff; // low byte parked until high byte arrives

  // core sequencer
  hdp_core_state_t coreState_ff;
  hdp_core_state_t nxt_coreState;
  logic coreReq;
  logic selData;
  logic selStat;
  logic stall;
  logic doAccess; // one-cycle pulse when an access is carried out
  logic doLoadData;
  logic doStoreData;
  logic doStoreStat;

  // interrupt state
  logic inPend_ff;
  logic outPend_ff;
  logic [`HDP_BLOCK_DELAY-1:0] blockPipe_ff; // block bit seen per instruction step
  logic inSet;
  logic outSet;
  logic inMasked;
  logic outMasked;

  // all host pins cross into clk; strobes idle high
  hdp_sync #(
    .WIDTH(13),
    .INIT(13'h1c00)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .asyncIn({hostCsN, hostRdN, hostWrN, hostAddr, hostDataIn}),
    .syncOut(hostSync)
  );

  assign csN = hostSync[12];
  assign rdN = hostSync[11];
  assign wrN = hostSync[10];
  assign hSel = hostSync[9:8];
  assign hData = hostSync[7:0];

  // strobe edge history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdNPrev_ff <= 1'b1;
      wrNPrev_ff <= 1'b1;
    end else begin
      rdNPrev_ff <= rdN;
      wrNPrev_ff <= wrN;
    end
  end

  // address and data sync with the strobe, so they are stable at its rise
  assign hostRdRise = rdN & ~rdNPrev_ff & ~csN & wrN;
  assign hostWrRise = wrN & ~wrNPrev_ff & ~csN & rdN;

  // core decode; both words share one address
  assign coreReq = coreLoad | coreStore;
  assign selData = (coreAddr == `HDP_ADDR_DATA);
  assign selStat = (coreAddr == `HDP_ADDR_STAT);

  // wait only when enabled and the word is not ready
  always_comb begin
    stall = 1'b0;
    if (status_ff[`HDP_BIT_WAITEN] && selData) begin
      if (coreStore && status_ff[`HDP_BIT_RDRDY]) begin
        stall = 1'b1;
      end else if (coreLoad && status_ff[`HDP_BIT_WRRDY]) begin
        stall = 1'b1;
      end
    end
  end

  // next state of the core sequencer
  always_comb begin
    nxt_coreState = coreState_ff;
    doAccess = 1'b0;
    unique case (coreState_ff)
      HDP_IDLE: begin
        if (coreReq && stall) begin
          nxt_coreState = HDP_STALL;
        end else if (coreReq) begin
          nxt_coreState = HDP_DONE;
          doAccess = 1'b1;
        end
      end
      HDP_STALL: begin
        // no timeout: only the host emptying or filling the word frees it
        if (!stall) begin
          nxt_coreState = HDP_DONE;
          doAccess = 1'b1;
        end
      end
      HDP_DONE: begin
        nxt_coreState = HDP_IDLE;
      end
      default: begin
        nxt_coreState = HDP_IDLE;
      end
    endcase
  end

  assign doLoadData = doAccess & coreLoad & selData;
  assign doStoreData = doAccess & coreStore & selData;
  assign doStoreStat = doAccess & coreStore & selStat;

  // sequencer state, ack and wait flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coreState_ff <= HDP_IDLE;
      coreAck_ff <= 1'b0;
      coreWait_ff <= 1'b0;
    end else begin
      coreState_ff <= nxt_coreState;
      coreAck_ff <= doAccess;
      coreWait_ff <= (nxt_coreState == HDP_STALL);
    end
  end

  // core read data; unmapped addresses read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coreRdData_ff <= 16'h0000;
    end else if (doAccess && coreLoad) begin
      if (selData) begin
        coreRdData_ff <= inWord_ff;
      end else if (selStat) begin
        coreRdData_ff <= status_ff & 16'h07ff;
      end else begin
        coreRdData_ff <= 16'h0000;
      end
    end
  end

  // host input bytes; data taken only while the word is free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inLow_ff <= 8'h00;
      inWord_ff <= 16'h0000;
    end else if (hostWrRise && status_ff[`HDP_BIT_WRRDY]) begin
      if (hSel == `HDP_HSEL_DATA_LO) begin
        inLow_ff <= hData;
      end else if (hSel == `HDP_HSEL_DATA_HI) begin
        inWord_ff <= {hData, inLow_ff};
      end
    end
  end

  // output word from core stores
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outWord_ff <= 16'h0000;
    end else if (doStoreData) begin
      outWord_ff <= coreWrData;
    end
  end

  // status word; hardware sets always win over program writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_ff <= `HDP_STAT_RESET;
    end else begin
      // program-writable fields and clear-only error flags
      if (doStoreStat) begin
        status_ff[10:6] <= coreWrData[10:6];
        status_ff[5:2] <= status_ff[5:2] & coreWrData[5:2];
      end
      // host write to data while not ready is an error
      if (hostWrRise && !hSel[1] && !status_ff[`HDP_BIT_WRRDY]) begin
        status_ff[`HDP_BIT_WRERR] <= 1'b1;
      end
      // host read of data while nothing is ready
      if (hostRdRise && !hSel[1] && !status_ff[`HDP_BIT_RDRDY]) begin
        status_ff[`HDP_BIT_RDERR] <= 1'b1;
      end
      // store over unread output, load of empty input
      if (doStoreData && status_ff[`HDP_BIT_RDRDY]) begin
        status_ff[`HDP_BIT_STERR] <= 1'b1;
      end
      if (doLoadData && status_ff[`HDP_BIT_WRRDY]) begin
        status_ff[`HDP_BIT_LDERR] <= 1'b1;
      end
      // write-ready: core load frees, host high byte fills
      if (doLoadData) begin
        status_ff[`HDP_BIT_WRRDY] <= 1'b1;
      end else if (hostWrRise && hSel == `HDP_HSEL_DATA_HI) begin
        status_ff[`HDP_BIT_WRRDY] <= 1'b0;
      end
      // read-ready: core store fills, host high-byte read empties
      if (doStoreData) begin
        status_ff[`HDP_BIT_RDRDY] <= 1'b1;
      end else if (hostRdRise && hSel == `HDP_HSEL_DATA_HI) begin
        status_ff[`HDP_BIT_RDRDY] <= 1'b0;
      end
    end
  end

  // ready pins follow the registered flags one cycle later unless masked; mask forces high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      writeReadyPinN_ff <= 1'b1;
      readReadyPinN_ff <= 1'b1;
    end else begin
      writeReadyPinN_ff <= ~(status_ff[`HDP_BIT_WRRDY] & ~status_ff[`HDP_BIT_WRMASK]);
      readReadyPinN_ff <= ~(status_ff[`HDP_BIT_RDRDY] & ~status_ff[`HDP_BIT_RDMASK]);
    end
  end

  // host read data bus; drive only during a selected read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hostDataOut_ff <= 8'h00;
      hostDataOe_ff <= 1'b0;
    end else begin
      hostDataOe_ff <= ~csN & ~rdN & wrN;
      unique case (hSel)
        `HDP_HSEL_DATA_LO: hostDataOut_ff <= outWord_ff[7:0];
        `HDP_HSEL_DATA_HI: hostDataOut_ff <= outWord_ff[15:8];
        `HDP_HSEL_STAT_LO: hostDataOut_ff <= status_ff[7:0];
        `HDP_HSEL_STAT_HI: hostDataOut_ff <= status_ff[15:8] & 8'h07;
      endcase
    end
  end

  // interrupt events from the host side
  assign inSet = hostWrRise & (hSel == `HDP_HSEL_DATA_HI) & status_ff[`HDP_BIT_WRRDY];
  assign outSet = hostRdRise & (hSel == `HDP_HSEL_DATA_HI);
  assign inMasked = |(coreStatusWord & `HDP_SR_IN_MASK);
  assign outMasked = |(coreStatusWord & `HDP_SR_OUT_MASK);

  // global block seen through a two-step instruction pipe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blockPipe_ff <= '0;
    end else if (instrStep) begin
      blockPipe_ff <= {blockPipe_ff[`HDP_BLOCK_DELAY-2:0],
                       |(irqEnableWord & `HDP_EIR_BLOCK_MASK)};
    end
  end

  // pending requests; masked ones are recorded, flush loses to a new event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inPend_ff <= 1'b0;
      outPend_ff <= 1'b0;
      irqReq_ff <= 1'b0;
      irqVector_ff <= 16'h0000;
    end else begin
      irqReq_ff <= 1'b0;
      if (flushIrq) begin
        inPend_ff <= 1'b0;
        outPend_ff <= 1'b0;
      end
      // stalled core takes no interrupt until the wait ends
      if (!blockPipe_ff[`HDP_BLOCK_DELAY-1] && !coreWait_ff && !irqReq_ff
          && !flushIrq && (nxt_coreState != HDP_STALL)) begin
        if (inPend_ff && !inMasked) begin
          inPend_ff <= 1'b0;
          irqReq_ff <= 1'b1;
          irqVector_ff <= `HDP_VEC_INPUT;
        end else if (outPend_ff && !outMasked) begin
          outPend_ff <= 1'b0;
          irqReq_ff <= 1'b1;
          irqVector_ff <= `HDP_VEC_OUTPUT;
        end
      end
      if (inSet) begin
        inPend_ff <= 1'b1;
      end
      if (outSet) begin
        outPend_ff <= 1'b1;
      end
    end
  end
endmodule // hdp_host_port

// ### shared/hdp_defines.svh
// constants for the host data port: offsets, bit positions, reset values, vectors
`ifndef HDP_DEFINES_SVH
`define HDP_DEFINES_SVH

// core peripheral addresses
`define HDP_ADDR_DATA 16'h3806
`define HDP_ADDR_STAT 16'h3807

// host select codes on the two address pins
`define HDP_HSEL_DATA_LO 2'h0
`define HDP_HSEL_DATA_HI 2'h1
`define HDP_HSEL_STAT_LO 2'h2
`define HDP_HSEL_STAT_HI 2'h3

// status word bit positions
`define HDP_BIT_WAITEN 10
`define HDP_BIT_RDMASK 9
`define HDP_BIT_WRMASK 8
`define HDP_BIT_USER1 7
`define HDP_BIT_USER0 6
`define HDP_BIT_RDERR 5
`define HDP_BIT_WRERR 4
`define HDP_BIT_STERR 3
`define HDP_BIT_LDERR 2
`define HDP_BIT_RDRDY 1
`define HDP_BIT_WRRDY 0

// status reset value and the mask of program-written bits
`define HDP_STAT_RESET 16'h0301
`define HDP_STAT_RW_MASK 16'h07c0
`define HDP_STAT_ERR_MASK 16'h003c

// core status and interrupt enable masks
`define HDP_SR_IRQ_MASK 16'h0300
`define HDP_SR_OUT_MASK 16'h0200
`define HDP_SR_IN_MASK 16'h0100
`define HDP_EIR_BLOCK_MASK 16'h8000

// interrupt vector table entries
`define HDP_VEC_INPUT 16'h0230
`define HDP_VEC_OUTPUT 16'h0234

// instruction cycles before a global block change takes hold
`define HDP_BLOCK_DELAY 2

`endif

// ### shared/hdp_pkg.sv
// types for the host data port
package hdp_pkg;

  // core access sequencer, one-hot
  typedef enum logic [2:0] {
    HDP_IDLE  = 3'b001,
    HDP_STALL = 3'b010,
    HDP_DONE  = 3'b100
  } hdp_core_state_t;

  // host byte select
  typedef logic [1:0] hdp_hsel_t;

endpackage

// ### design/hdp_sync.sv
// two-flop synchroniser for a bundle of host pins
`timescale 1ns/1ps
module hdp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous level in, synchronous level out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_ff; // first stage, read only by the second

  // two stages; reset value keeps strobes idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= INIT;
      syncOut <= INIT;
    end else begin
      meta_ff <= asyncIn;
      syncOut <= meta_ff;
    end
  end
endmodule // hdp_sync

// ### test/hdp_host_port_asserts.sv
// checker for the host data port top ports
`timescale 1ns/1ps
module hdp_host_port_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // core side
  input wire logic coreLoad,
  input wire logic coreStore,
  input wire logic coreAck_ff,
  input wire logic coreWait_ff,
  input wire logic [15:0] coreStatusWord,
  input wire logic [15:0] irqEnableWord,
  input wire logic instrStep,
  input wire logic irqReq_ff,
  input wire logic [15:0] irqVector_ff,
  // ready pins
  input wire logic writeReadyPinN_ff,
  input wire logic readReadyPinN_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ack is a lone pulse answering a held request
  a_ack_pulse: assert property (coreAck_ff |=> !coreAck_ff)
    else $error("ack longer than one cycle");
  a_ack_req: assert property (coreAck_ff |-> $past(coreLoad || coreStore))
    else $error("ack without request");
  // a stall only stands behind a held request
  a_wait_req: assert property (coreWait_ff |-> (coreLoad || coreStore))
    else $error("wait without request");
  // no interrupt is taken while the core is stalled
  a_no_irq_wait: assert property (coreWait_ff |-> !irqReq_ff)
    else $error("interrupt during wait");
  a_irq_space: assert property (irqReq_ff |=> !irqReq_ff)
    else $error("interrupts back to back");
  a_vec_legal: assert property (irqReq_ff |-> irqVector_ff inside {16'h0230, 16'h0234})
    else $error("bad vector");
  // mask held over the deciding cycle must block the source
  a_in_mask: assert property ((irqReq_ff && irqVector_ff == 16'h0230) |->
      !($past(coreStatusWord[8]) && coreStatusWord[8])) else $error("input irq masked");
  a_out_mask: assert property ((irqReq_ff && irqVector_ff == 16'h0234) |->
      !($past(coreStatusWord[9]) && coreStatusWord[9])) else $error("output irq masked");
  // global block, settled over several steps, stops everything
  a_block_all: assert property ((irqEnableWord[15] && instrStep) [*5] |-> !irqReq_ff)
    else $error("irq while blocked");
  a_reset_pins: assert property ($past(rst) |-> writeReadyPinN_ff && readReadyPinN_ff)
    else $error("pins not masked after reset");
endmodule // hdp_host_port_chk

bind hdp_host_port hdp_host_port_chk chk_u (.clk(clk), .rst(rst), .coreLoad(coreLoad),
  .coreStore(coreStore), .coreAck_ff(coreAck_ff), .coreWait_ff(coreWait_ff),
  .coreStatusWord(coreStatusWord), .irqEnableWord(irqEnableWord), .instrStep(instrStep),
  .irqReq_ff(irqReq_ff), .irqVector_ff(irqVector_ff),
  .writeReadyPinN_ff(writeReadyPinN_ff), .readReadyPinN_ff(readReadyPinN_ff));

// ### test/hdp_host_model.sv
// host processor model on the byte-wide strobe pins
`timescale 1ns/1ps
module hdp_host_model (
  // clock
  input wire logic clk,
  // strobes, select and write data
  output logic hostCsN,
  output logic hostRdN,
  output logic hostWrN,
  output hdp_pkg::hdp_hsel_t hostAddr,
  output logic [7:0] hostDataIn,
  // read data from the port
  input wire logic [7:0] hostDataOut_ff
);
  import hdp_pkg::*;
  // idle bus at time zero
  initial begin
    hostCsN = 1'h1;
    hostRdN = 1'h1;
    hostWrN = 1'h1;
    hostAddr = 2'h0;
    hostDataIn = 8'h00;
  end
  // one byte cycle; six clocks low, well over the three-clock sync minimum
  task automatic hostCycle(input logic isWr, input hdp_hsel_t sel, input logic [7:0] wd,
      output logic [7:0] rd);
    @(negedge clk);
    hostCsN = 1'h0;
    hostAddr = sel;
    hostDataIn = wd;
    hostWrN = !isWr;
    hostRdN = isWr;
    repeat (6) @(negedge clk);
    rd = hostDataOut_ff;
    hostWrN = 1'h1;
    hostRdN = 1'h1;
    // select and data held past the synchroniser lag
    repeat (4) @(negedge clk);
    hostCsN = 1'h1;
    // released bus shows the inverse, never a stale copy
    hostDataIn = ~wd;
    repeat (5) @(negedge clk);
  endtask
endmodule // hdp_host_model

// ### test/tb_hdp_host_port.sv
// self-checking bench for the host data port
`timescale 1ns/1ps
`include "hdp_defines.svh"
module tb_hdp_host_port;
  import hdp_pkg::*;
  // design signals
  logic clk, rst, coreLoad, coreStore, instrStep, flushIrq, coreAck_ff, coreWait_ff;
  logic irqReq_ff, hostDataOe_ff, writeReadyPinN_ff, readReadyPinN_ff;
  logic hostCsN, hostRdN, hostWrN;
  hdp_hsel_t hostAddr;
  logic [15:0] coreAddr, coreWrData, coreStatusWord, irqEnableWord, coreRdData_ff;
  logic [15:0] irqVector_ff, d, lastVec;
  logic [7:0] hostDataIn, hostDataOut_ff, b;
  int errCount, compares, irqCnt, n0;
  // rows: host low byte, host high byte, expected word
  logic [31:0] rowTab [3] = '{32'h0000_0000, 32'h5AA5_A55A, 32'hFF80_80FF};
  hdp_host_port dut_u (.clk(clk), .rst(rst), .coreAddr(coreAddr), .coreLoad(coreLoad),
    .coreStore(coreStore), .coreWrData(coreWrData), .coreRdData_ff(coreRdData_ff),
    .coreAck_ff(coreAck_ff), .coreWait_ff(coreWait_ff), .coreStatusWord(coreStatusWord),
    .irqEnableWord(irqEnableWord), .instrStep(instrStep), .flushIrq(flushIrq),
    .irqReq_ff(irqReq_ff), .irqVector_ff(irqVector_ff), .hostCsN(hostCsN), .hostRdN(hostRdN),
    .hostWrN(hostWrN), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
    .hostDataOut_ff(hostDataOut_ff), .hostDataOe_ff(hostDataOe_ff),
    .writeReadyPinN_ff(writeReadyPinN_ff), .readReadyPinN_ff(readReadyPinN_ff));
  hdp_host_model host_u (.clk(clk), .hostCsN(hostCsN), .hostRdN(hostRdN), .hostWrN(hostWrN),
    .hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut_ff(hostDataOut_ff));
  // 40 MHz clock
  initial clk = 1'h0;
  always #12.5 clk = ~clk;
  // interrupt monitor, sampled where outputs are settled
  always @(negedge clk) begin
    if (irqReq_ff === 1'h1) begin
      irqCnt++;
      lastVec = irqVector_ff;
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errCount++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // core access held until ack, dropped in the ack cycle
  task automatic core(input logic st, input logic [15:0] a, input logic [15:0] w);
    int n;
    @(negedge clk);
    coreAddr = a;
    coreWrData = w;
    coreStore = st;
    coreLoad = !st;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (coreAck_ff !== 1'h1 && n < 400);
    if (n >= 400) errCount++;
    d = coreRdData_ff;
    coreLoad = 1'h0;
    coreStore = 1'h0;
  endtask
  task automatic hw(input hdp_hsel_t s, input logic [7:0] v);
    host_u.hostCycle(1'h1, s, v, b);
  endtask
  task automatic hr(input hdp_hsel_t s);
    host_u.hostCycle(1'h0, s, 8'h00, b);
  endtask
  task automatic giveVerdict();
    $display("compares %0d errors %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog, about forty times the expected run
  initial begin
    #500000;
    errCount++;
    giveVerdict();
  end
  initial begin
    {coreLoad, coreStore, flushIrq, instrStep} = 4'h1;
    {coreAddr, coreWrData, coreStatusWord, irqEnableWord} = 64'h0;
    rst = 1'h1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    core(0, `HDP_ADDR_STAT, 0);
    chk("status", 16'h0301, d);
    chk("data oe", 0, hostDataOe_ff);
    chk("wr pin", 1, writeReadyPinN_ff);
    core(1, `HDP_ADDR_STAT, 16'h0000);
    repeat (3) @(negedge clk);
    chk("wr pin", 0, writeReadyPinN_ff);
    $display("test reset done");
    foreach (rowTab[i]) begin
      n0 = irqCnt;
      hw(`HDP_HSEL_DATA_LO, rowTab[i][31:24]);
      hw(`HDP_HSEL_DATA_HI, rowTab[i][23:16]);
      chk("wr pin", 1, writeReadyPinN_ff);
      chk("irq count", 16'(n0 + 1), 16'(irqCnt));
      chk("vector", `HDP_VEC_INPUT, lastVec);
      core(0, `HDP_ADDR_STAT, 0);
      chk("status", 16'h0000, d);
      core(0, `HDP_ADDR_DATA, 0);
      chk("word", rowTab[i][15:0], d);
      repeat (3) @(negedge clk);
      chk("wr pin", 0, writeReadyPinN_ff);
      core(0, `HDP_ADDR_STAT, 0);
      chk("status", 16'h0001, d);
    end
    $display("test rows done");
    n0 = irqCnt;
    core(1, `HDP_ADDR_DATA, 16'hC3A5);
    core(0, `HDP_ADDR_STAT, 0);
    chk("status", 16'h0003, d);
    chk("rd pin", 0, readReadyPinN_ff);
    fork
      hr(`HDP_HSEL_DATA_LO);
      begin
        repeat (6) @(negedge clk);
        chk("data oe", 1, hostDataOe_ff);
      end
    join
    chk("out lo", 16'h00A5, 16'(b));
    hr(`HDP_HSEL_DATA_HI);
    chk("out hi", 16'h00C3, 16'(b));
    chk("irq count", 16'(n0 + 1), 16'(irqCnt));
    chk("vector", `HDP_VEC_OUTPUT, lastVec);
    $display("test output done");
    coreStatusWord = `HDP_SR_IRQ_MASK;
    n0 = irqCnt;
    hw(`HDP_HSEL_DATA_HI, 8'h5A);
    chk("masked irq", 16'(n0), 16'(irqCnt));
    coreStatusWord = 16'h0000;
    repeat (4) @(negedge clk);
    chk("pending irq", 16'(n0 + 1), 16'(irqCnt));
    core(0, `HDP_ADDR_DATA, 0);
    chk("hi only", 16'h005A, 16'(d[15:8]));
    irqEnableWord = `HDP_EIR_BLOCK_MASK;
    repeat (4) @(negedge clk);
    hw(`HDP_HSEL_DATA_HI, 8'h22);
    hw(`HDP_HSEL_DATA_HI, 8'h33);
    flushIrq = 1'h1;
    @(negedge clk);
    flushIrq = 1'h0;
    irqEnableWord = 16'h0000;
    repeat (6) @(negedge clk);
    chk("blocked irq", 16'(n0 + 1), 16'(irqCnt));
    core(0, `HDP_ADDR_STAT, 0);
    chk("status", 16'h0010, d);
    core(0, `HDP_ADDR_DATA, 0);
    chk("kept byte", 16'h0022, 16'(d[15:8]));
    $display("test irq done");
    core(1, `HDP_ADDR_STAT, 16'h0400);
    core(0, `HDP_ADDR_STAT, 0);
    chk("status", 16'h0401, d);
    fork
      core(0, `HDP_ADDR_DATA, 0);
      begin
        repeat (20) @(negedge clk);
        chk("load wait", 1, coreWait_ff);
        hw(`HDP_HSEL_DATA_LO, 8'h34);
        hw(`HDP_HSEL_DATA_HI, 8'h12);
      end
    join
    chk("word", 16'h1234, d);
    core(1, `HDP_ADDR_DATA, 16'hBEEF);
    fork
      core(1, `HDP_ADDR_DATA, 16'h7788);
      begin
        repeat (40) @(negedge clk);
        chk("store wait", 1, coreWait_ff);
        hr(`HDP_HSEL_DATA_LO);
        hr(`HDP_HSEL_DATA_HI);
      end
    join
    hr(`HDP_HSEL_DATA_LO);
    hr(`HDP_HSEL_DATA_HI);
    chk("second word", 16'h0077, 16'(b));
    $display("test wait done");
    coreStatusWord = `HDP_SR_OUT_MASK;
    n0 = irqCnt;
    core(1, `HDP_ADDR_DATA, 16'h9966);
    hr(`HDP_HSEL_DATA_LO);
    hr(`HDP_HSEL_DATA_HI);
    chk("out masked", 16'(n0), 16'(irqCnt));
    coreStatusWord = 16'h0000;
    repeat (4) @(negedge clk);
    chk("out pending", 16'(n0 + 1), 16'(irqCnt));
    $display("test burst mask done");
    giveVerdict();
  end
endmodule // tb_hdp_host_port
